// ---- lane_frame_pkg.sv ----
// Shared constants and types for the lane framing user interface.
// Assumes lanes carry two-byte code groups and byte 0 is most significant.
package lane_frame_pkg;

  // ----------------------------------------------------------------------
  // Channel geometry
  // ----------------------------------------------------------------------
  localparam int LANE_COUNT = 4;          // Lanes in the channel
  localparam int BYTES_PER_LANE = 2;      // Bytes per lane per clock
  localparam int DELIM_BYTES = 2;         // Width of one delimiter pair

  // ----------------------------------------------------------------------
  // Clock compensation timing
  // ----------------------------------------------------------------------
  localparam int CC_SPACING_BYTES = 10000; // Bytes per lane between runs
  localparam int CC_LEN_CLOCKS = 6;        // Clocks that one run takes
  localparam int CC_TIMER_W = 16;          // Width of the interval timer

  // ----------------------------------------------------------------------
  // Control character codes (flagged by ctrl = 1 on the channel)
  // ----------------------------------------------------------------------
  localparam logic [7:0] CODE_START1 = 8'h5C; // Start delimiter, first byte
  localparam logic [7:0] CODE_START2 = 8'hFB; // Start delimiter, second byte
  localparam logic [7:0] CODE_END1 = 8'hFD;   // End delimiter, first byte
  localparam logic [7:0] CODE_END2 = 8'hFE;   // End delimiter, second byte
  localparam logic [7:0] CODE_PAD = 8'h9C;  // Pad for odd frames
  localparam logic [7:0] CODE_IDLE = 8'hBC; // Idle filler
  localparam logic [7:0] CODE_CC = 8'hF7;   // Clock compensation

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  // One byte position of the channel word
  typedef struct packed {
    logic ctrl;
    logic [7:0] code;
  } ch_byte_t;

  // Transmit sequencing
  typedef enum {TX_RUN, TX_GAP, TX_CC} tx_state_t;

  localparam ch_byte_t IDLE_CH = '{ctrl: 1'b1, code: CODE_IDLE};
  localparam ch_byte_t CC_CH = '{ctrl: 1'b1, code: CODE_CC};
  localparam ch_byte_t PAD_CH = '{ctrl: 1'b1, code: CODE_PAD};

endpackage

// ---- lane_frame_user_app.sv ----
// User application model: sinks the receive stream into a byte queue.
// Assumes receive outputs are registered and settle after each edge.
`timescale 1ns/10ps
module lane_frame_user_app (
  // Clock
  input wire logic clk_in,
  // Receive stream
  input wire logic [63:0] rx_data_in,
  input wire logic [7:0] rx_keep_in,
  input wire logic rx_last_in,
  input wire logic rx_valid_in
);
  // ----------------------------------------------------------------------
  // Receive sink
  // ----------------------------------------------------------------------
  logic [7:0] rx_bytes[$]; // Elastic store on the receive path
  int frames_done = 0; // Frames closed by last
  int n; // Bytes taken from this beat

  // Take every valid beat at once, skip cycles without valid
  always @(posedge clk_in) begin
    if (rx_valid_in) begin
      n = rx_last_in ? $countones(rx_keep_in) : 8;
      for (int i = 0; i < n; i++) begin
        rx_bytes.push_back(rx_data_in[63-8*i -: 8]);
      end
      if (rx_last_in) begin
        frames_done++;
      end
    end
  end
endmodule

// ---- lane_frame_user_interface.sv ----
// Framing user interface: stream in, framed channel words out, and back.
// Assumes one clock for both directions and a partner that never stalls
// the receive port.
// How it works
// - Idle characters fill channel when nothing sent
// - Beat taken when valid meets held ready
// - Start delimiter first, then first n-2 bytes
// - Last two beat bytes slip one word
// - Ready drops; gap carries tail and end
// - Ready returns the cycle after the gap
// - Odd frames get one pad character appended
// - Short final beat sends only kept bytes
// - Missing valid mid-frame sends idles instead
// - Paused frame still flushes held bytes first
// - Compensation run inserted every 10,000 lane bytes
// - Interval is 5,000 or 2,500 clocks
// - Compensation suspends user data six clocks
// - Receiver strips delimiters, idles, compensation characters
// - Valid with first word, last with final
// - Keep gives count of bytes when last
// - Receive valid may drop at any cycle
// - Receiver left-aligns bytes with least latency
// - Start in top lane, end in bottom
// - Most significant byte travels first
`timescale 1ns/10ps
module lane_frame_user_interface #(
  parameter int LANES = lane_frame_pkg::LANE_COUNT,
  parameter int BPL = lane_frame_pkg::BYTES_PER_LANE,
  parameter int CC_INTERVAL = lane_frame_pkg::CC_SPACING_BYTES / BPL
) (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RESET_IN,
  // Transmit stream from the user
  input wire logic [8*LANES*BPL-1:0] TX_DATA_IN,
  input wire logic [LANES*BPL-1:0] TX_KEEP_IN,
  input wire logic TX_LAST_IN,
  input wire logic TX_VALID_IN,
  output logic TX_READY_OUT,
  // Channel words toward the lanes
  output lane_frame_pkg::ch_byte_t [0:LANES*BPL-1] CH_TX_OUT,
  // Channel words from the lanes
  input wire lane_frame_pkg::ch_byte_t [0:LANES*BPL-1] CH_RX_IN,
  // Receive stream to the user
  output logic [8*LANES*BPL-1:0] RX_DATA_OUT,
  output logic [LANES*BPL-1:0] RX_KEEP_OUT,
  output logic RX_LAST_OUT,
  output logic RX_VALID_OUT
);

  // ----------------------------------------------------------------------
  // Geometry and checks
  // ----------------------------------------------------------------------
  localparam int WB = LANES * BPL;         // Bytes per channel word
  localparam int CW = $clog2(2 * WB + 1);  // Width of receive byte count
  localparam int DB = lane_frame_pkg::DELIM_BYTES;
  localparam int CCL = lane_frame_pkg::CC_LEN_CLOCKS;
  localparam int TW = lane_frame_pkg::CC_TIMER_W;

  // Refuse shapes the word packing cannot serve
  if (BPL != 2 && BPL != 4) begin : g_bad_bpl
    $error("Bytes per lane must be 2 or 4");
  end
  if (WB < 2 * DB) begin : g_bad_width
    $error("Channel word must hold at least four bytes");
  end
  if (CC_INTERVAL <= CCL + 2 || CC_INTERVAL >= (1 << TW)) begin : g_bad_cc
    $error("Compensation interval out of range");
  end

  // Number of kept bytes in a beat, assuming they are left-aligned
  function automatic int keep_count(input logic [WB-1:0] k);
    int c;
    c = 0;
    for (int i = 0; i < WB; i++) begin
      c = c + int'(k[i]);
    end
    return c;
  endfunction

  // Keep mask with the first c bytes set, most significant first
  function automatic logic [WB-1:0] keep_mask(input int c);
    logic [WB-1:0] m;
    m = '0;
    for (int i = 0; i < WB; i++) begin
      m[WB-1-i] = (i < c);
    end
    return m;
  endfunction

  // ----------------------------------------------------------------------
  // Transmit state
  // ----------------------------------------------------------------------
  lane_frame_pkg::tx_state_t tx_state;     // Sequencing state
  lane_frame_pkg::tx_state_t next_state;
  logic in_frame;                          // Frame opened and not closed
  logic next_in_frame;
  logic [1:0][7:0] hold;                   // Tail bytes slipped a word
  logic [1:0][7:0] next_hold;
  logic [1:0] hold_n;                      // How many tail bytes are held
  logic [1:0] next_hold_n;
  logic [2:0] cc_left;                     // Compensation clocks to go
  logic [2:0] next_cc_left;
  logic [TW-1:0] cc_timer;                 // Interval timer
  logic cc_due;                            // Compensation is owed
  logic tx_accept;                         // Beat taken this edge
  lane_frame_pkg::ch_byte_t [0:WB-1] next_word;

  // Ready only in the run state and when no compensation is owed
  assign TX_READY_OUT = (tx_state == lane_frame_pkg::TX_RUN)
                        && !cc_due;
  assign tx_accept = TX_VALID_IN && TX_READY_OUT;

  // ----------------------------------------------------------------------
  // Transmit word builder
  // ----------------------------------------------------------------------
  // Builds the next channel word; positions default to idle
  always_comb begin
    int v;
    v = TX_LAST_IN ? keep_count(TX_KEEP_IN) : WB;
    for (int i = 0; i < WB; i++) begin
      next_word[i] = lane_frame_pkg::IDLE_CH;
    end
    next_state = tx_state;
    next_in_frame = in_frame;
    next_hold = hold;
    next_hold_n = hold_n;
    next_cc_left = cc_left;
    case (tx_state)
      lane_frame_pkg::TX_RUN: begin
        if (cc_due) begin
          // First clock of a compensation run
          for (int i = 0; i < WB; i++) begin
            next_word[i] = lane_frame_pkg::CC_CH;
          end
          next_cc_left = 3'(CCL - 2);
          next_state = lane_frame_pkg::TX_CC;
        end else if (tx_accept) begin
          // Lead pair: start delimiter or the slipped tail
          if (!in_frame) begin
            next_word[0] = '{1'b1, lane_frame_pkg::CODE_START1};
            next_word[1] = '{1'b1, lane_frame_pkg::CODE_START2};
          end else if (hold_n == 2'h2) begin
            next_word[0] = '{1'b0, hold[0]};
            next_word[1] = '{1'b0, hold[1]};
          end
          // Body: first WB-2 bytes, most significant first
          for (int i = 0; i < WB - DB; i++) begin
            if (i < v) begin
              next_word[i+DB] = '{1'b0, TX_DATA_IN[8*(WB-1-i) +: 8]};
            end else if (i == v && v[0]) begin
              next_word[i+DB] = lane_frame_pkg::PAD_CH;
            end
          end
          // Last two bytes slip to the next word
          next_hold[0] = TX_DATA_IN[8*(DB-1) +: 8];
          next_hold[1] = TX_DATA_IN[7:0];
          next_hold_n = (v > WB - DB) ? 2'(v - (WB - DB)) : 2'h0;
          next_in_frame = 1'b1;
          if (TX_LAST_IN) begin
            next_state = lane_frame_pkg::TX_GAP;
          end
        end else if (in_frame && hold_n == 2'h2) begin
          // Pause: flush the tail on lane 0, idles elsewhere
          next_word[0] = '{1'b0, hold[0]};
          next_word[1] = '{1'b0, hold[1]};
          next_hold_n = 2'h0;
        end
      end
      lane_frame_pkg::TX_GAP: begin
        // Tail bytes, pad if odd, idles, end delimiter in last lane
        if (hold_n != 2'h0) begin
          next_word[0] = '{1'b0, hold[0]};
        end
        if (hold_n == 2'h2) begin
          next_word[1] = '{1'b0, hold[1]};
        end else if (hold_n == 2'h1) begin
          next_word[1] = lane_frame_pkg::PAD_CH;
        end
        next_word[WB-2] = '{1'b1, lane_frame_pkg::CODE_END1};
        next_word[WB-1] = '{1'b1, lane_frame_pkg::CODE_END2};
        next_hold_n = 2'h0;
        next_in_frame = 1'b0;
        next_state = lane_frame_pkg::TX_RUN;
      end
      lane_frame_pkg::TX_CC: begin
        // Remaining compensation clocks, user data held off
        for (int i = 0; i < WB; i++) begin
          next_word[i] = lane_frame_pkg::CC_CH;
        end
        if (cc_left == 3'h0) begin
          next_state = lane_frame_pkg::TX_RUN;
        end else begin
          next_cc_left = cc_left - 3'h1;
        end
      end
      default: begin
        next_state = lane_frame_pkg::TX_RUN;
      end
    endcase
  end

  // Transmit sequencing registers
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      tx_state <= lane_frame_pkg::TX_RUN;
      in_frame <= 1'b0;
      hold <= '0;
      hold_n <= 2'h0;
      cc_left <= 3'h0;
    end else begin
      tx_state <= next_state;
      in_frame <= next_in_frame;
      hold <= next_hold;
      hold_n <= next_hold_n;
      cc_left <= next_cc_left;
    end
  end

  // Channel word output register
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      for (int i = 0; i < WB; i++) begin
        CH_TX_OUT[i] <= lane_frame_pkg::IDLE_CH;
      end
    end else begin
      CH_TX_OUT <= next_word;
    end
  end

  // ----------------------------------------------------------------------
  // Compensation scheduler
  // ----------------------------------------------------------------------
  // Free-running interval; a run owed stays owed until it starts
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      cc_timer <= '0;
      cc_due <= 1'b0;
    end else begin
      if (tx_state == lane_frame_pkg::TX_RUN && cc_due) begin
        cc_due <= 1'b0;
      end
      if (cc_timer == TW'(CC_INTERVAL - 1)) begin
        cc_timer <= '0;
        cc_due <= 1'b1;
      end else begin
        cc_timer <= cc_timer + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------------
  logic [7:0] acc [0:2*WB-1];        // Left-aligned user bytes
  logic [7:0] next_acc [0:2*WB-1];
  logic [CW-1:0] rcnt;               // Bytes held in the accumulator
  logic [CW-1:0] next_rcnt;
  logic pend;                        // Final partial word still owed
  logic next_pend;
  logic rx_frame;                    // Inside a received frame
  logic next_rx_frame;
  logic next_valid;
  logic next_last;
  logic [WB-1:0] next_keep;
  logic [8*WB-1:0] next_data;

  // Strips control characters, packs user bytes, emits words
  always_comb begin
    int n;
    logic end_seen;
    logic [7:0] m [0:2*WB-1];
    n = pend ? 0 : int'(rcnt);
    end_seen = 1'b0;
    next_rx_frame = rx_frame;
    for (int j = 0; j < 2 * WB; j++) begin
      m[j] = pend ? 8'h00 : acc[j];
    end
    for (int i = 0; i < WB; i++) begin
      if (CH_RX_IN[i].ctrl) begin
        // Only delimiters matter; idles, pad and compensation drop out
        if (CH_RX_IN[i].code == lane_frame_pkg::CODE_START1) begin
          next_rx_frame = 1'b1;
        end else if (CH_RX_IN[i].code == lane_frame_pkg::CODE_END2
                     && next_rx_frame) begin
          end_seen = 1'b1;
          next_rx_frame = 1'b0;
        end
      end else if (next_rx_frame && n < 2 * WB) begin
        m[n] = CH_RX_IN[i].code;
        n = n + 1;
      end
    end
    next_valid = 1'b0;
    next_last = 1'b0;
    next_keep = '1;
    next_data = RX_DATA_OUT;
    next_acc = m;
    next_rcnt = CW'(n);
    next_pend = 1'b0;
    if (pend) begin
      // Owed final word goes out; new bytes start a fresh word
      for (int i = 0; i < WB; i++) begin
        next_data[8*(WB-1-i) +: 8] = acc[i];
      end
      next_valid = 1'b1;
      next_last = 1'b1;
      next_keep = keep_mask(int'(rcnt));
    end else if (end_seen && n > 0 && n <= WB) begin
      // Whole tail fits one word
      for (int i = 0; i < WB; i++) begin
        next_data[8*(WB-1-i) +: 8] = m[i];
      end
      next_valid = 1'b1;
      next_last = 1'b1;
      next_keep = keep_mask(n);
      next_rcnt = '0;
    end else if (n >= WB) begin
      // Full word out; remainder shifts to the front
      for (int i = 0; i < WB; i++) begin
        next_data[8*(WB-1-i) +: 8] = m[i];
      end
      for (int j = 0; j < 2 * WB; j++) begin
        next_acc[j] = (j < WB) ? m[j+WB] : 8'h00;
      end
      next_valid = 1'b1;
      next_rcnt = CW'(n - WB);
      next_pend = end_seen;
    end
  end

  // Receive accumulator registers
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      for (int j = 0; j < 2 * WB; j++) begin
        acc[j] <= 8'h00;
      end
      rcnt <= '0;
      pend <= 1'b0;
      rx_frame <= 1'b0;
    end else begin
      acc <= next_acc;
      rcnt <= next_rcnt;
      pend <= next_pend;
      rx_frame <= next_rx_frame;
    end
  end

  // Receive stream output registers
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      RX_DATA_OUT <= '0;
      RX_KEEP_OUT <= '1;
      RX_LAST_OUT <= 1'b0;
      RX_VALID_OUT <= 1'b0;
    end else begin
      RX_DATA_OUT <= next_data;
      RX_KEEP_OUT <= next_keep;
      RX_LAST_OUT <= next_last;
      RX_VALID_OUT <= next_valid;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_gap_ready_low: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    tx_accept && TX_LAST_IN |=> !TX_READY_OUT
      && CH_TX_OUT[WB-1] != {1'b1, lane_frame_pkg::CODE_END2})
    else $error("ready not dropped after final beat");

  a_ready_returns: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    tx_accept && TX_LAST_IN |=> ##1 (TX_READY_OUT || cc_due))
    else $error("ready not back after end gap");

  a_start_delim: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    tx_accept && !in_frame |=>
      CH_TX_OUT[0] == {1'b1, lane_frame_pkg::CODE_START1}
      && CH_TX_OUT[1] == {1'b1, lane_frame_pkg::CODE_START2})
    else $error("frame start lacks start delimiter");

  a_end_lane: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    tx_state == lane_frame_pkg::TX_GAP |=>
      CH_TX_OUT[WB-1] == {1'b1, lane_frame_pkg::CODE_END2})
    else $error("end delimiter missing from last lane");

  a_idle_fill: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    TX_READY_OUT && !TX_VALID_IN && !in_frame |=>
      CH_TX_OUT[0] == lane_frame_pkg::IDLE_CH
      && CH_TX_OUT[WB-1] == lane_frame_pkg::IDLE_CH)
    else $error("no idles while nothing is sent");

  a_pause_flush: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    TX_READY_OUT && !TX_VALID_IN && in_frame && hold_n == 2'h2 |=>
      CH_TX_OUT[0].code == $past(hold[0]) && hold_n == 2'h0)
    else $error("held bytes not flushed in pause");

  a_odd_pad: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    tx_state == lane_frame_pkg::TX_GAP && hold_n == 2'h1 |=>
      CH_TX_OUT[1] == lane_frame_pkg::PAD_CH)
    else $error("odd frame not padded");

  a_cc_six_low: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    tx_state == lane_frame_pkg::TX_RUN && cc_due |->
      !TX_READY_OUT [*6] ##1 TX_READY_OUT)
    else $error("compensation hold not six clocks");

  a_cc_period: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    $rose(cc_due) |-> cc_timer == '0)
    else $error("compensation owed off interval");

  a_rx_last_valid: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    RX_LAST_OUT |-> RX_VALID_OUT && RX_KEEP_OUT[WB-1])
    else $error("last without valid or empty keep");

endmodule

// ---- lane_frame_user_interface_test.sv ----
// Testbench: frames looped from the channel output back to its input.
// Assumes the default four lanes of two bytes and a short CC interval.
`timescale 1ns/10ps
module lane_frame_user_interface_test;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  typedef lane_frame_pkg::ch_byte_t [0:7] word_t;
  localparam int CCI = 100; // Shortened compensation interval
  localparam lane_frame_pkg::ch_byte_t IDL = lane_frame_pkg::IDLE_CH;
  logic clk, rst; // Clock and reset
  logic [63:0] tx_data; // Transmit stream
  logic [7:0] tx_keep;
  logic tx_last, tx_valid, tx_ready;
  word_t ch; // Channel word, looped back
  logic [63:0] rx_data; // Receive stream
  logic [7:0] rx_keep;
  logic rx_last, rx_valid;
  int num_errors = 0, tests_run = 0, cycles = 0;
  word_t exp_q[$], obs_q[$]; // Expected and seen framed words
  logic [7:0] sent[$]; // User bytes of the current frame

  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end

  lane_frame_user_interface #(.CC_INTERVAL(CCI)) u_dut (
    .SYS_CLK_IN(clk), .RESET_IN(rst), .TX_DATA_IN(tx_data),
    .TX_KEEP_IN(tx_keep), .TX_LAST_IN(tx_last), .TX_VALID_IN(tx_valid),
    .TX_READY_OUT(tx_ready), .CH_TX_OUT(ch), .CH_RX_IN(ch),
    .RX_DATA_OUT(rx_data), .RX_KEEP_OUT(rx_keep), .RX_LAST_OUT(rx_last),
    .RX_VALID_OUT(rx_valid));

  lane_frame_user_app u_app (.clk_in(clk), .rx_data_in(rx_data),
    .rx_keep_in(rx_keep), .rx_last_in(rx_last), .rx_valid_in(rx_valid));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic bit all_of(word_t w, lane_frame_pkg::ch_byte_t c);
    all_of = 1;
    for (int i = 0; i < 8; i++) begin
      if (w[i] !== c) all_of = 0;
    end
  endfunction

  task automatic check(string what, logic [71:0] got, logic [71:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    if (num_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Log framed words, dropping idle and compensation words; cut hangs
  always @(negedge clk) begin
    cycles++;
    if (!rst && !all_of(ch, IDL) && !all_of(ch, lane_frame_pkg::CC_CH)) begin
      obs_q.push_back(ch);
    end
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end

  // Wait until a compensation run has just ended
  task automatic cc_sync();
    while (!all_of(ch, lane_frame_pkg::CC_CH)) @(negedge clk);
    while (!tx_ready) @(negedge clk);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // State after reset: idles, ready, no receive beat
  task automatic check_reset();
    check("reset_idle", 72'(all_of(ch, IDL)), 72'(1));
    check("reset_ready", 72'(tx_ready), 72'(1));
    check("reset_rx_valid", 72'(rx_valid), 72'(0));
  endtask

  // Send n bytes, optional pause after beat pb, checking both directions
  task automatic send_frame(int n, int pb, bit sync);
    int nb, k, f0;
    word_t w;
    lane_frame_pkg::ch_byte_t held[2];
    lane_frame_pkg::ch_byte_t c;
    logic [7:0] b;
    if (sync) cc_sync();
    nb = (n + 7) / 8;
    f0 = u_app.frames_done;
    held[0] = '{1'b1, lane_frame_pkg::CODE_START1}; // Start opens frame
    held[1] = '{1'b1, lane_frame_pkg::CODE_START2};
    exp_q.delete();
    obs_q.delete();
    sent.delete();
    u_app.rx_bytes.delete();
    for (int j = 0; j < nb; j++) begin
      k = (j == nb - 1) ? n - 8 * j : 8;
      tx_valid = 1;
      tx_last = (j == nb - 1); // Last marks final beat
      tx_keep = 8'hFF << (8 - k); // Kept byte count
      w[0] = held[0];
      w[1] = held[1];
      for (int i = 0; i < 8; i++) begin
        b = 8'(n * 7 + 8 * j + i);
        tx_data[63-8*i -: 8] = b; // First byte in the top bits
        if (i < k) begin
          c = '{1'b0, b};
          sent.push_back(b);
        end else begin
          c = (i == k && k % 2 == 1) ? lane_frame_pkg::PAD_CH : IDL;
        end
        if (i < 6) w[i+2] = c;
        else held[i-6] = c;
      end
      while (!tx_ready) @(negedge clk);
      exp_q.push_back(w);
      @(negedge clk);
      if (j == nb - 1) begin
        tx_valid = 0;
        tx_last = 0;
        check("ready_gap", 72'(tx_ready), 72'(0));
        w = '{held[0], held[1], IDL, IDL, IDL, IDL,
              '{1'b1, lane_frame_pkg::CODE_END1},
              '{1'b1, lane_frame_pkg::CODE_END2}};
        exp_q.push_back(w);
        @(negedge clk);
        if (sync) check("ready_back", 72'(tx_ready), 72'(1));
      end else if (j == pb) begin
        tx_valid = 0;
        tx_data = ~tx_data; // Ignored while valid is low
        while (!tx_ready) @(negedge clk);
        @(negedge clk);
        w = '{held[0], held[1], IDL, IDL, IDL, IDL, IDL, IDL};
        exp_q.push_back(w);
        held[0] = IDL;
        held[1] = IDL;
      end
    end
    repeat (8) @(negedge clk);
    check("tx_words", 72'(obs_q.size()), 72'(exp_q.size()));
    for (int i = 0; i < exp_q.size() && i < obs_q.size(); i++) begin
      check("tx_word", obs_q[i], exp_q[i]);
    end
    check("rx_count", 72'(u_app.rx_bytes.size()), 72'(n));
    for (int i = 0; i < n && i < u_app.rx_bytes.size(); i++) begin
      check("rx_byte", 72'(u_app.rx_bytes[i]), 72'(sent[i]));
    end
    check("rx_frames", 72'(u_app.frames_done), 72'(f0 + 1));
  endtask

  // Compensation while idle: length, characters and spacing
  task automatic cc_test();
    int t, c;
    t = 0;
    c = 0;
    cc_sync();
    while (tx_ready) @(negedge clk);
    while (!tx_ready) begin
      @(negedge clk);
      t++;
      if (all_of(ch, lane_frame_pkg::CC_CH)) c++;
    end
    check("cc_ready_low", 72'(t), 72'(6));
    check("cc_words", 72'(c), 72'(6));
    while (tx_ready) begin
      @(negedge clk);
      t++;
    end
    check("cc_period", 72'(t), 72'(CCI));
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst = 1;
    tx_valid = 0;
    tx_last = 0;
    tx_keep = 8'h00;
    tx_data = 64'h0;
    repeat (20) @(negedge clk);
    rst = 0;
    check_reset();
    send_frame(24, -1, 1); // Three full beats
    send_frame(23, -1, 1); // Short final beat with pad
    send_frame(24, 0, 1); // Pause after the first beat
    for (int n = 1; n <= 9; n++) begin
      send_frame(n, -1, 1); // Every final-beat length
    end
    cc_test();
    send_frame(800, 3, 0); // Long frame across compensation
    test_done();
  end
endmodule
